// File: rtl/rmc_config_sampler.sv
// Purpose: capture reset-time mode straps and apply them to the core pins
// Assumes: sys_rst synchronous to clock, interrupt pins active low
// Notes: config becomes valid three edges after reset release
`timescale 1ns/1ps
`default_nettype none
module rmc_config_sampler
  import rmc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] intPin,
  output logic [5:0] intToCore,
  input wire logic fpIrq,
  input wire logic fpUnitBusy,
  output logic coprocBranchCond1,
  input wire logic [1:0] coreAddrHi,
  input wire logic [1:0] lowAddrIn,
  output logic [1:0] lowAddrOut,
  output logic [1:0] lowAddrOe,
  output logic snoopInvalidate,
  output logic snoopStall,
  output logic coprocBranchCond2,
  output logic coprocBranchCond3,
  input wire logic tagMatch,
  output logic cacheHit,
  input wire logic instrReq,
  input wire logic dataReq,
  output logic instrCacheEn,
  output logic dataCacheEn,
  input wire logic userMode,
  output logic effBigEndian,
  input wire logic dataParityErr,
  input wire logic tagParityErr,
  output logic parityErrReport,
  output logic configValid,
  output logic [1:0] dataRefillBlockSize,
  output logic [1:0] instrRefillBlockSize,
  output logic extendedCacheSize,
  output logic bigEndian,
  output logic snoopAddrDisable,
  output logic outputFloatSelect,
  output logic parityDisplayOrReverseOrder,
  output logic instrStreamingEnable,
  output logic parityCheckOff,
  output logic cachelessOperation,
  output logic partialStoreEnable,
  output logic multiprocessorEnable,
  output logic busDriveKeep,
  output logic [2:0] fpIrqRouteCode,
  output logic fpIrqOnBranchCond,
  output logic enhancedDeviceMode,
  output logic translationBufferOff,
  output logic [1:0] tagMode
);
  typedef struct packed {
    rmc_state_t state;
    logic [23:0] cfg;
    logic [2:0] ctrl;
    logic [31:0] rdata;
    logic slverr;
    logic [5:0] irq;
    logic cond1;
    logic [1:0] addrOut;
    logic [1:0] addrOe;
    logic snInv;
    logic snStall;
    logic cond2;
    logic cond3;
    logic hit;
    logic iEn;
    logic dEn;
    logic effBe;
    logic parErr;
  } rmc_core_t;

  rmc_core_t st_r;
  rmc_core_t st_nxt;
  logic [5:0] intSync;
  logic [1:0] addrSync;
  logic [23:0] intHistory;

  // decode an APB address to a register select
  function automatic logic [1:0] regSel(input logic [11:0] a);
    unique case (a)
      RMC_OFS_CONFIG: regSel = RMC_SEL_CONFIG;
      RMC_OFS_CONTROL: regSel = RMC_SEL_CONTROL;
      RMC_OFS_STATUS: regSel = RMC_SEL_STATUS;
      default: regSel = RMC_SEL_NONE;
    endcase
  endfunction

  // which interrupt line the fp interrupt replaces, none if external
  function automatic logic [2:0] routeLine(input logic [2:0] code);
    if (code == FP_ROUTE_DEFAULT) begin
      routeLine = FP_DEFAULT_LINE;
    end else if (code == FP_ROUTE_EXT) begin
      routeLine = FP_LINE_NONE;
    end else begin
      routeLine = code;
    end
  endfunction

  rmc_pin_sampler u_sampler (
    .clock(clock),
    .intPin(intPin),
    .addrPinIn(lowAddrIn),
    .intSync(intSync),
    .addrSync(addrSync),
    .intHistory(intHistory)
  );

  logic valid;
  logic pinIn;
  logic [2:0] fpCode;
  logic [2:0] fpLine;
  logic [1:0] sel;
  logic setup;
  logic wrAcc;
  logic revNow;
  assign valid = (st_r.state == RMC_RUN);
  assign fpCode = {st_r.cfg[CFG_FPR2], st_r.cfg[CFG_FPR1],
                   st_r.cfg[CFG_FPR0]};
  assign fpLine = routeLine(fpCode);
  // pins become inputs when multiprocessor or snoop address disable is on
  assign pinIn = st_r.cfg[CFG_MPEN] | st_r.cfg[CFG_SNOOP_ADIS];
  assign sel = regSel(paddr);
  assign setup = psel & ~penable;
  assign wrAcc = psel & penable & pwrite;
  // reverse order needs the strap option, software consent and user mode
  assign revNow = st_r.cfg[CFG_REVORD] & st_r.ctrl[CTL_USER_REV] & userMode;

  // next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    // state walk: two alignment cycles cover the synchroniser delay
    unique case (st_r.state)
      RMC_RST: st_nxt.state = RMC_AL1;
      RMC_AL1: st_nxt.state = RMC_AL2;
      RMC_AL2: begin
        st_nxt.state = RMC_RUN;
        // history now holds pins of the last four reset cycles
        for (int n = 0; n < RMC_LINES; n++) begin
          for (int c = 0; c < RMC_CYC; c++) begin
            st_nxt.cfg[n*RMC_CYC+c] = intHistory[(RMC_CYC-1-c)*RMC_LINES+n];
          end
        end
      end
      RMC_RUN: st_nxt.state = RMC_RUN;
    endcase
    // read data is prepared in the setup phase, so zero wait states
    if (setup) begin
      st_nxt.slverr = (sel == RMC_SEL_NONE);
      st_nxt.rdata = 32'h00000000;
      unique case (sel)
        RMC_SEL_CONFIG: st_nxt.rdata[23:0] = st_r.cfg;
        RMC_SEL_CONTROL: st_nxt.rdata[2:0] = st_r.ctrl;
        RMC_SEL_STATUS: begin
          st_nxt.rdata[STS_VALID] = valid;
          st_nxt.rdata[STS_EFF_BE] = st_r.effBe;
          st_nxt.rdata[STS_PIN_IN] = pinIn;
          st_nxt.rdata[STS_ROUTE_LO+:3] = fpLine;
        end
        RMC_SEL_NONE: st_nxt.rdata = 32'h00000000;
      endcase
    end
    if (wrAcc && sel == RMC_SEL_CONTROL) begin
      st_nxt.ctrl = pwdata[2:0];
    end
    // interrupt lines to the core, active high inside
    st_nxt.irq = 6'h00;
    if (valid) begin
      st_nxt.irq = ~intSync;
      if (fpLine != FP_LINE_NONE) begin
        st_nxt.irq[fpLine] = fpIrq;
      end
    end
    // cond 1 pin shows busy unless the straps chose the interrupt
    st_nxt.cond1 = st_r.cfg[CFG_FPCOND] ? fpIrq : fpUnitBusy;
    // multifunction low address pins
    st_nxt.addrOut = coreAddrHi;
    st_nxt.addrOe = {2{valid & ~pinIn}};
    st_nxt.snInv = valid & st_r.cfg[CFG_MPEN] & addrSync[0];
    st_nxt.snStall = valid & st_r.cfg[CFG_MPEN] & addrSync[1];
    st_nxt.cond2 = valid & ~st_r.cfg[CFG_MPEN] & pinIn & addrSync[0];
    st_nxt.cond3 = valid & ~st_r.cfg[CFG_MPEN] & pinIn & addrSync[1];
    // isolation makes the tag compare irrelevant
    st_nxt.hit = st_r.ctrl[CTL_ISOLATE] | tagMatch;
    // swap routes each request to the other cache
    if (st_r.ctrl[CTL_SWAP]) begin
      st_nxt.iEn = dataReq;
      st_nxt.dEn = instrReq;
    end else begin
      st_nxt.iEn = instrReq;
      st_nxt.dEn = dataReq;
    end
    st_nxt.effBe = st_r.cfg[CFG_BIGEND] ^ revNow;
    st_nxt.parErr = (dataParityErr | tagParityErr)
                    & ~st_r.cfg[CFG_PAROFF];
  end

  // synchronous reset; board releases it on a clock edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.state <= RMC_RST;
      st_r.cfg <= CFG_RESET;
      st_r.ctrl <= CTL_RESET;
      st_r.rdata <= 32'h00000000;
      st_r.slverr <= 1'b0;
      st_r.irq <= 6'h00;
      st_r.cond1 <= 1'b0;
      st_r.addrOut <= 2'h0;
      st_r.addrOe <= 2'h0;
      st_r.snInv <= 1'b0;
      st_r.snStall <= 1'b0;
      st_r.cond2 <= 1'b0;
      st_r.cond3 <= 1'b0;
      st_r.hit <= 1'b0;
      st_r.iEn <= 1'b0;
      st_r.dEn <= 1'b0;
      st_r.effBe <= 1'b0;
      st_r.parErr <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus answers at once; no wait states are ever needed
  assign pready = 1'b1;
  assign prdata = st_r.rdata;
  assign pslverr = st_r.slverr;
  assign intToCore = st_r.irq;
  assign coprocBranchCond1 = st_r.cond1;
  assign lowAddrOut = st_r.addrOut;
  assign lowAddrOe = st_r.addrOe;
  assign snoopInvalidate = st_r.snInv;
  assign snoopStall = st_r.snStall;
  assign coprocBranchCond2 = st_r.cond2;
  assign coprocBranchCond3 = st_r.cond3;
  assign cacheHit = st_r.hit;
  assign instrCacheEn = st_r.iEn;
  assign dataCacheEn = st_r.dEn;
  assign effBigEndian = st_r.effBe;
  assign parityErrReport = st_r.parErr;
  assign configValid = valid;
  // decoded straps straight from the captured word
  assign dataRefillBlockSize = {st_r.cfg[CFG_DBLK1],
                                st_r.cfg[CFG_DBLK0]};
  assign extendedCacheSize = st_r.cfg[CFG_EXTCACHE];
  assign bigEndian = st_r.cfg[CFG_BIGEND];
  assign instrRefillBlockSize = {st_r.cfg[CFG_IBLK1],
                                 st_r.cfg[CFG_IBLK0]};
  assign snoopAddrDisable = st_r.cfg[CFG_SNOOP_ADIS];
  assign outputFloatSelect = st_r.cfg[CFG_FLOAT];
  assign parityDisplayOrReverseOrder = st_r.cfg[CFG_REVORD];
  assign instrStreamingEnable = st_r.cfg[CFG_INSTR_STREAMING_ENABLE];
  assign parityCheckOff = st_r.cfg[CFG_PAROFF];
  assign cachelessOperation = st_r.cfg[CFG_CACHELESS_OPERATION];
  // reserved strap is stored in the config word only
  assign partialStoreEnable = st_r.cfg[CFG_PSTORE];
  assign multiprocessorEnable = st_r.cfg[CFG_MPEN];
  assign busDriveKeep = st_r.cfg[CFG_BUSKEEP];
  assign fpIrqRouteCode = fpCode;
  assign fpIrqOnBranchCond = st_r.cfg[CFG_FPCOND];
  assign enhancedDeviceMode = st_r.cfg[CFG_ENH];
  assign translationBufferOff = st_r.cfg[CFG_TLBOFF];
  assign tagMode = {st_r.cfg[CFG_TAGM1], st_r.cfg[CFG_TAGM0]};
endmodule
`default_nettype wire

// File: rtl/rmc_pin_sampler.sv
// Purpose: two-stage synchronisers for all input pins, strap history for the interrupt pins only
// Assumes: pins are asynchronous to clock
// Notes: history shifts every cycle, word 0 holds the newest sample
`timescale 1ns/1ps
`default_nettype none
module rmc_pin_sampler
  import rmc_pkg::*;
(
  input wire logic clock,
  input wire logic [5:0] intPin,
  input wire logic [1:0] addrPinIn,
  output logic [5:0] intSync,
  output logic [1:0] addrSync,
  output logic [23:0] intHistory
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [3:0][5:0] hist;
  } rmc_samp_t;

  rmc_samp_t st_r;
  rmc_samp_t st_nxt;

  // sync stages carry no reset: a reset would only load a constant anyway
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {addrPinIn, intPin};
    st_nxt.s2 = st_r.s1;
    st_nxt.hist[0] = st_r.s2[5:0];
    for (int i = 1; i < RMC_CYC; i++) begin
      st_nxt.hist[i] = st_r.hist[i-1];
    end
  end

  always_ff @(posedge clock) begin
    st_r <= st_nxt;
  end

  assign intSync = st_r.s2[5:0];
  assign addrSync = st_r.s2[7:6];
  assign intHistory = st_r.hist;
endmodule
`default_nettype wire

// File: rtl/rmc_pkg.sv
// Purpose: shared constants and types of the reset mode config sampler
// Assumes: 10 MHz clock, synchronous active-high reset, APB registers
// Notes: config word bit = line * 4 + cycle, cycle 0 is the first
package rmc_pkg;
  localparam int RMC_LINES = 6;
  localparam int RMC_CYC = 4;
  localparam int RMC_CFG_W = 24;
  localparam int RMC_HIST_W = 24;
  // bus map
  localparam int RMC_AW = 12;
  localparam logic [11:0] RMC_OFS_CONFIG = 12'h000;
  localparam logic [11:0] RMC_OFS_CONTROL = 12'h004;
  localparam logic [11:0] RMC_OFS_STATUS = 12'h008;
  localparam logic [1:0] RMC_SEL_CONFIG = 2'h0;
  localparam logic [1:0] RMC_SEL_CONTROL = 2'h1;
  localparam logic [1:0] RMC_SEL_STATUS = 2'h2;
  localparam logic [1:0] RMC_SEL_NONE = 2'h3;
  // control register fields
  localparam int CTL_ISOLATE = 0;
  localparam int CTL_SWAP = 1;
  localparam int CTL_USER_REV = 2;
  localparam logic [2:0] CTL_RESET = 3'h0;
  // status register fields
  localparam int STS_VALID = 0;
  localparam int STS_EFF_BE = 1;
  localparam int STS_PIN_IN = 2;
  localparam int STS_ROUTE_LO = 3;
  // captured config word fields
  localparam int CFG_DBLK0 = 0;
  localparam int CFG_DBLK1 = 1;
  localparam int CFG_EXTCACHE = 2;
  localparam int CFG_BIGEND = 3;
  localparam int CFG_IBLK0 = 4;
  localparam int CFG_IBLK1 = 5;
  localparam int CFG_SNOOP_ADIS = 6;
  localparam int CFG_FLOAT = 7;
  localparam int CFG_REVORD = 8;
  localparam int CFG_INSTR_STREAMING_ENABLE = 9;
  localparam int CFG_PAROFF = 10;
  localparam int CFG_CACHELESS_OPERATION = 11;
  localparam int CFG_RSVD = 12;
  localparam int CFG_PSTORE = 13;
  localparam int CFG_MPEN = 14;
  localparam int CFG_BUSKEEP = 15;
  localparam int CFG_FPR2 = 16;
  localparam int CFG_FPR1 = 17;
  localparam int CFG_FPR0 = 18;
  localparam int CFG_FPCOND = 19;
  localparam int CFG_ENH = 20;
  localparam int CFG_TLBOFF = 21;
  localparam int CFG_TAGM1 = 22;
  localparam int CFG_TAGM0 = 23;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  // fp interrupt routing codes
  localparam logic [2:0] FP_ROUTE_DEFAULT = 3'h7;
  localparam logic [2:0] FP_ROUTE_EXT = 3'h6;
  localparam logic [2:0] FP_DEFAULT_LINE = 3'h3;
  localparam logic [2:0] FP_LINE_NONE = 3'h7;
  typedef enum logic [1:0] {
    RMC_RST = 2'b00,
    RMC_AL1 = 2'b01,
    RMC_AL2 = 2'b11,
    RMC_RUN = 2'b10
  } rmc_state_t;
endpackage

// File: tb/rmc_config_sampler_asserts.sv
// Purpose: port-level checks of the config sampler
// Assumes: one clock domain, sys_rst synchronous
// Notes: settled means config valid on two edges in a row
`timescale 1ns/1ps
`default_nettype none
module rmc_config_sampler_asserts
  import rmc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic configValid,
  input wire logic [1:0] dataRefillBlockSize,
  input wire logic bigEndian,
  input wire logic [2:0] fpIrqRouteCode,
  input wire logic [1:0] tagMode,
  input wire logic fpIrqOnBranchCond,
  input wire logic fpIrq,
  input wire logic fpUnitBusy,
  input wire logic coprocBranchCond1,
  input wire logic parityErrReport,
  input wire logic dataParityErr,
  input wire logic tagParityErr,
  input wire logic parityCheckOff,
  input wire logic [1:0] lowAddrOe,
  input wire logic [1:0] lowAddrOut,
  input wire logic [1:0] coreAddrHi,
  input wire logic multiprocessorEnable,
  input wire logic snoopAddrDisable,
  input wire logic tagMatch,
  input wire logic cacheHit,
  input wire logic instrReq,
  input wire logic dataReq,
  input wire logic instrCacheEn,
  input wire logic dataCacheEn,
  input wire logic userMode,
  input wire logic effBigEndian
);
  logic settled_r;
  logic settled;
  // settled hides the edge where config first lands, $past sees old 0s
  always_ff @(posedge clock) begin
    if (sys_rst) settled_r <= 1'b0;
    else settled_r <= configValid;
  end
  assign settled = configValid & settled_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_valid_delay: assert property (
    $fell(sys_rst) |-> !configValid[*3] ##1 configValid)
    else $error("config valid late");
  a_cfg_held: assert property (
    settled |-> $stable({dataRefillBlockSize, bigEndian, fpIrqRouteCode,
    tagMode, fpIrqOnBranchCond}))
    else $error("config moved");
  a_parity_mask: assert property (
    settled |-> parityErrReport ==
    $past((dataParityErr | tagParityErr) & !parityCheckOff))
    else $error("parity report wrong");
  a_cond1_select: assert property (
    settled |-> coprocBranchCond1 ==
    $past(fpIrqOnBranchCond ? fpIrq : fpUnitBusy))
    else $error("cond1 source wrong");
  a_pin_input: assert property (
    settled && (multiprocessorEnable || snoopAddrDisable) |->
    lowAddrOe == 2'h0)
    else $error("pins still driven");
  a_addr_drive: assert property (
    settled && !(multiprocessorEnable || snoopAddrDisable) |->
    lowAddrOe == 2'h3 && lowAddrOut == $past(coreAddrHi))
    else $error("address pins wrong");
  a_tag_hit: assert property (
    settled && $past(tagMatch) |-> cacheHit)
    else $error("match gave no hit");
  a_req_route: assert property (
    settled && $past(instrReq == dataReq) |->
    instrCacheEn == $past(instrReq) && dataCacheEn == $past(dataReq))
    else $error("request routing wrong");
  a_user_order: assert property (
    settled && !$past(userMode) |-> effBigEndian == bigEndian)
    else $error("byte order wrong");
  cover property (settled && multiprocessorEnable);
  cover property (settled && cacheHit && !$past(tagMatch));
  cover property (settled && effBigEndian != bigEndian);
endmodule
bind rmc_config_sampler rmc_config_sampler_asserts chk (.*);
`default_nettype wire

// File: tb/rmc_config_sampler_bench.sv
// Purpose: self-checking bench of the config sampler
// Assumes: straps come from the board model, APB with no wait states
// Notes: rows hold strap words and expected interrupt lines
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin \
  numErrors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module rmc_config_sampler_bench
  import rmc_pkg::*;
;
  typedef struct packed {logic [23:0] w; logic [5:0] irq;} rmc_row_t;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, go, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] intPin, intToCore, runPins;
  logic fpIrq, fpUnitBusy, coprocBranchCond1, snoopInvalidate, snoopStall;
  logic coprocBranchCond2, coprocBranchCond3, tagMatch, cacheHit, err;
  logic instrReq, dataReq, instrCacheEn, dataCacheEn, userMode, effBigEndian;
  logic dataParityErr, tagParityErr, parityErrReport, configValid, bigEndian;
  logic [1:0] coreAddrHi, lowAddrIn, lowAddrOut, lowAddrOe, tagMode;
  logic [1:0] dataRefillBlockSize, instrRefillBlockSize;
  logic extendedCacheSize, snoopAddrDisable, outputFloatSelect;
  logic parityDisplayOrReverseOrder, instrStreamingEnable, parityCheckOff;
  logic cachelessOperation, partialStoreEnable, multiprocessorEnable;
  logic busDriveKeep, fpIrqOnBranchCond, enhancedDeviceMode;
  logic translationBufferOff;
  logic [2:0] fpIrqRouteCode;
  logic [23:0] strapWord, w;
  int numErrors = 0;
  int checksDone = 0;
  rmc_row_t rows [4] = '{'{24'h000000, 6'h3E}, '{24'hFFFFFF, 6'h37},
    '{24'h930250, 6'h3F}, '{24'h0A0509, 6'h3B}};
  rmc_config_sampler dut (.*);
  rmc_strap_board board (.*);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // APB master: holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      numErrors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // observed config outputs, laid out like the strap word
  function automatic logic [23:0] seen();
    seen = {tagMode[0], tagMode[1], translationBufferOff, enhancedDeviceMode,
      fpIrqOnBranchCond, fpIrqRouteCode[0], fpIrqRouteCode[1],
      fpIrqRouteCode[2], busDriveKeep, multiprocessorEnable,
      partialStoreEnable, 1'b1, cachelessOperation, parityCheckOff,
      instrStreamingEnable, parityDisplayOrReverseOrder, outputFloatSelect,
      snoopAddrDisable, instrRefillBlockSize, bigEndian, extendedCacheSize,
      dataRefillBlockSize};
  endfunction
  initial begin
    {psel, penable, pwrite, paddr, pwdata, go, strapWord, runPins} = '0;
    {fpIrq, tagMatch, instrReq, dataReq, userMode, tagParityErr} = '0;
    {fpUnitBusy, dataParityErr} = 2'b11;
    coreAddrHi = 2'h1;
    lowAddrIn = 2'h2;
    repeat (12) @(posedge clock);
    `CHK("reset state", 2'b10, {pready, configValid})
    // one full reset per row, each row with its own strap word
    for (int i = 0; i < 4; i++) begin
      w = rows[i].w | 24'h001000;
      strapWord <= rows[i].w;
      runPins <= 6'h00;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (3) @(posedge clock);
      for (int n = 0; configValid !== 1'b1; n++) begin
        if (n > 40) begin
          numErrors++;
          report_and_stop();
        end
        @(posedge clock);
      end
      repeat (4) @(posedge clock);
      `CHK("config outputs", w, seen())
      `CHK("irq lines", rows[i].irq, intToCore)
      `CHK("parity", ~w[10], parityErrReport)
      `CHK("cond1", ~w[19], coprocBranchCond1)
      `CHK("pin roles", {w[14], 1'b0, w[6] & ~w[14], 1'b0}, {snoopStall,
        snoopInvalidate, coprocBranchCond3, coprocBranchCond2})
      runPins <= 6'h2A;
      apb(0, RMC_OFS_CONFIG, 32'h0);
      `CHK("config reg", {8'h00, w}, rd)
      `CHK("after reset", w, seen())
      $display("row %0d done", i);
    end
    // control bits, user byte order, refused accesses
    {userMode, instrReq} <= 2'b11;
    apb(1, RMC_OFS_CONTROL, 32'h7);
    apb(0, RMC_OFS_CONTROL, 32'h0);
    `CHK("control", 32'h7, rd)
    `CHK("isolate hit", 1'b1, cacheHit)
    `CHK("swap", 2'b01, {instrCacheEn, dataCacheEn})
    `CHK("user order", 1'b0, effBigEndian)
    apb(0, RMC_OFS_STATUS, 32'h0);
    `CHK("status", 32'h00000011, rd)
    apb(1, RMC_OFS_CONFIG, 32'h0);
    apb(1, 12'h00C, 32'hF);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(0, RMC_OFS_CONFIG, 32'h0);
    `CHK("config kept", {8'h00, w}, rd)
    $display("awkward cases done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: tb/rmc_strap_board.sv
// Purpose: board reset logic that drives the mode straps
// Assumes: one go pulse per reset, strapWord holds pin levels
// Notes: pins follow runPins once reset is released
`timescale 1ns/1ps
`default_nettype none
module rmc_strap_board (
  input wire logic clock,
  input wire logic go,
  input wire logic [23:0] strapWord,
  input wire logic [5:0] runPins,
  output logic sys_rst,
  output logic [5:0] intPin,
  output logic done
);
  logic busy;
  logic [5:0] strap;
  // straps own the pins only while reset is held
  assign intPin = busy ? strap : runPins;
  function automatic logic [5:0] cyc(input logic [23:0] w, input int c);
    for (int n = 0; n < 6; n++) cyc[n] = w[n * 4 + c];
    if (c == 0) cyc[3] = 1'b1;
  endfunction
  // reset sequence: long stable lead-in, then the four strap cycles
  initial begin
    sys_rst = 1'b1;
    busy = 1'b1;
    strap = 6'h3F;
    done = 1'b0;
    forever begin
      @(posedge clock);
      done <= 1'b0;
      if (go) begin
        sys_rst <= 1'b1;
        busy <= 1'b1;
        strap <= cyc(strapWord, 0);
        repeat (8) @(posedge clock);
        for (int c = 1; c < 4; c++) begin
          @(posedge clock);
          strap <= cyc(strapWord, c);
        end
        @(posedge clock);
        sys_rst <= 1'b0;
        busy <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
